//--- include/csc_pkg.sv
// Constants and carriers for the socket status-change interrupt block
package csc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses within the socket register space
   localparam logic [11:0] CSC_SOCKET_BASE = 12'h800;
   localparam logic [7:0] CSC_IDX_IGC = 8'h03;
   localparam logic [7:0] CSC_IDX_FLAGS = 8'h04;
   localparam logic [7:0] CSC_IDX_MASK = 8'h05;
   localparam logic [7:0] CSC_IDX_GCTL = 8'h1E;
   localparam logic [7:0] CSC_COMPAT_BASE_A = 8'h00;
   localparam logic [7:0] CSC_COMPAT_BASE_B = 8'h40;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CSC_FLAG_DETECT = 3;
   localparam int CSC_FLAG_READY = 2;
   localparam int CSC_FLAG_BATLOW = 1;
   localparam int CSC_FLAG_BATTERY_DEAD_FLAG = 0;
   localparam int CSC_IGC_RING = 7;
   localparam int CSC_IGC_CARD_IO = 5;
   localparam int CSC_IGC_PCI_ROUTE = 4;
   localparam int CSC_GCTL_CLEAR_MODE = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Routing select codes and reset values
   localparam logic [3:0] CSC_SEL_NONE = 4'h0;
   localparam logic [3:0] CSC_SEL_IRQ1 = 4'h1;
   localparam logic [3:0] CSC_SEL_SMI = 4'h2;
   localparam logic [7:0] CSC_REG_RST = 8'h00;
   localparam logic [3:0] CSC_FLAGS_RST = 4'h0;
   localparam logic [15:0] CSC_IRQ_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [1:0] detect_n;
      logic ready;
      logic status_n;
      logic warn_n;
   } csc_card_s;

   // Empty, idle socket: detect lines high, battery lines good
   localparam csc_card_s CSC_CARD_RST = '{detect_n: 2'h3, ready: 1'b0, status_n: 1'b1, warn_n: 1'b1};

   typedef struct packed {
      logic rd;
      logic wr;
      logic compat;
      logic [11:0] addr;
      logic [7:0] wdata;
   } csc_req_s;

   typedef struct packed {
      csc_card_s card_meta;
      csc_card_s card_sync;
      csc_card_s card_prev;
      logic [3:0] flags;
      logic [7:0] route_mask;
      logic [7:0] igc;
      logic [7:0] gctl;
      logic [7:0] rdata;
      logic [15:0] isa_irq;
      logic smi;
      logic pci_int;
   } csc_state_s;

endpackage

//--- logic/csc_irq.sv
// Status-change detection, flag register and interrupt steering for one socket
`timescale 1ns/1ps

// Behaviour
// - A flag whose source enable is off always reads 0.
// - An enabled source becoming active sets its flag until software clears it.
// - Flags clear on status read or by writing 1, chosen by global control bit 2.
// - Status bits 7 to 4 always read as zero.
// - Status bit 3 sets on a change of either card-detect line.
// - Memory card: status bit 2 sets on a READY low-to-high transition.
// - I/O card: status bit 2 always reads 0.
// - Memory card: bit 1 flags battery warning; I/O card: bit 1 reads 0.
// - Bit 0 flags battery dead for memory cards, STSCHG assertion for I/O cards.
// - With ring indicate enabled, status bit 0 shows the ring indicate state.
// - Select field 7:4: 0 none, 1 IRQ1, 2 SMI, n gives IRQn.
// - Select 0 with diagnostic bit set routes to PCI, ignoring the route bit.
// - Select 0 with diagnostic bit clear reaches PCI only if route bit set.
// - Config bit 3 enables card-detect change events, default off.
// - Config bit 2 enables READY rising events, default off.
// - Config bit 1 enables battery warning events, default off.
// - Config bit 0 enables battery dead or STSCHG events, default off.
// - Status register at socket base plus 04h (804h) and compatibility index 04h or 44h.
// - Control bit 4 set sends status-change interrupts to PCI instead.
// - Control bit 5 selects memory card (0) or I/O card (1) behaviour.
// - Control bit 7 switches the status input to ring indicate operation.
module csc_irq #(
   parameter bit SOCKET_B = 1'b0
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire csc_pkg::csc_req_s i_req,
   input wire logic i_diag_event_pci_route,
   input wire logic [1:0] i_card_detect_n,
   input wire logic i_card_ready,
   input wire logic i_card_status_n,
   input wire logic i_card_warn_n,
   output logic [7:0] o_reg_rdata,
   output logic [15:0] o_isa_irq,
   output logic o_smi,
   output logic o_pci_int
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Compatibility accesses use the per-socket index window
   function automatic logic reg_hit(input csc_pkg::csc_req_s req, input logic [7:0] idx);
      logic [7:0] base;
      base = SOCKET_B ? csc_pkg::CSC_COMPAT_BASE_B : csc_pkg::CSC_COMPAT_BASE_A;
      if (req.compat) begin
         reg_hit = (req.addr[7:0] == 8'(base + idx));
      end else begin
         reg_hit = (req.addr == 12'(csc_pkg::CSC_SOCKET_BASE + {4'h0, idx}));
      end
   endfunction

   // What software sees in the status register
   function automatic logic [7:0] flag_view(
      input logic [3:0] flags,
      input logic [7:0] route_mask,
      input logic [7:0] igc,
      input logic status_n
   );
      logic [7:0] view;
      view = {4'h0, flags & route_mask[3:0]};
      if (igc[csc_pkg::CSC_IGC_CARD_IO]) begin
         view[csc_pkg::CSC_FLAG_READY] = 1'b0;
         view[csc_pkg::CSC_FLAG_BATLOW] = 1'b0;
      end
      if (igc[csc_pkg::CSC_IGC_RING]) begin
         // Live level, not latched: ring is a state, not an event
         view[csc_pkg::CSC_FLAG_BATTERY_DEAD_FLAG] = ~status_n & route_mask[csc_pkg::CSC_FLAG_BATTERY_DEAD_FLAG];
      end
      flag_view = view;
   endfunction

   // Gather the card pins into one word for the synchroniser
   function automatic csc_pkg::csc_card_s card_pins(
      input logic [1:0] detect_n,
      input logic ready,
      input logic status_n,
      input logic warn_n
   );
      csc_pkg::csc_card_s pins;
      pins.detect_n = detect_n;
      pins.ready = ready;
      pins.status_n = status_n;
      pins.warn_n = warn_n;
      card_pins = pins;
   endfunction

   // Edge events from the last two synchronised samples of the card pins
   function automatic logic [3:0] edge_events(
      input csc_pkg::csc_card_s sync,
      input csc_pkg::csc_card_s prev,
      input logic card_io,
      input logic ring_on
   );
      logic [3:0] seen;
      seen = 4'h0;
      // Only the active edge counts for ready, warning and status; detect sets on any change
      seen[csc_pkg::CSC_FLAG_DETECT] = |(sync.detect_n ^ prev.detect_n);
      seen[csc_pkg::CSC_FLAG_READY] = sync.ready & ~prev.ready & ~card_io;
      seen[csc_pkg::CSC_FLAG_BATLOW] = ~sync.warn_n & prev.warn_n & ~card_io;
      // Same pin is battery dead for memory cards and STSCHG for I/O cards
      seen[csc_pkg::CSC_FLAG_BATTERY_DEAD_FLAG] = ~sync.status_n & prev.status_n & ~ring_on;
      edge_events = seen;
   endfunction

   // Read data for one decoded register; unmapped reads return zero
   function automatic logic [7:0] read_mux(
      input logic [3:0] hits,
      input logic [7:0] view,
      input logic [7:0] route_mask,
      input logic [7:0] igc,
      input logic [7:0] gctl
   );
      logic [7:0] data;
      data = csc_pkg::CSC_REG_RST;
      if (hits[0]) begin
         data = view;
      end else if (hits[1]) begin
         data = route_mask;
      end else if (hits[2]) begin
         data = igc;
      end else if (hits[3]) begin
         data = gctl;
      end
      read_mux = data;
   endfunction

   // Bits that a status access clears; the mode bit picks read-clear or write-one-clear
   function automatic logic [3:0] clear_pick(
      input logic write_mode,
      input logic rd_hit,
      input logic wr_hit,
      input logic [3:0] wdata,
      input logic [3:0] shown
   );
      logic [3:0] bits;
      bits = 4'h0;
      if (write_mode) begin
         if (wr_hit) begin
            bits = wdata;
         end
      end else begin
         if (rd_hit) begin
            // Only bits actually returned are cleared, so a flag set meanwhile survives
            bits = shown;
         end
      end
      clear_pick = bits;
   endfunction

   // Set wins over a clear in the same cycle; a disabled source keeps no flag
   function automatic logic [3:0] next_flags(
      input logic [3:0] flags,
      input logic [3:0] clear,
      input logic [3:0] armed,
      input logic [3:0] enables
   );
      next_flags = ((flags & ~clear) | armed) & enables;
   endfunction

   // Global control keeps only the clear-mode bit; the other bits read zero
   function automatic logic [7:0] gctl_keep(input logic [7:0] wdata);
      logic [7:0] kept;
      kept = csc_pkg::CSC_REG_RST;
      kept[csc_pkg::CSC_GCTL_CLEAR_MODE] = wdata[csc_pkg::CSC_GCTL_CLEAR_MODE];
      gctl_keep = kept;
   endfunction

   // The interrupt follows the masked view, so a hidden flag never raises a line
   function automatic logic any_pending(input logic [7:0] view);
      any_pending = |view[3:0];
   endfunction

   // One ISA line per select code; codes 0 and 2 carry no ISA line
   function automatic logic [15:0] isa_line(input logic [3:0] sel);
      logic [15:0] line;
      case (sel)
         4'h0: line = 16'h0000;
         4'h1: line = 16'h0002;
         4'h2: line = 16'h0000;
         4'h3: line = 16'h0008;
         4'h4: line = 16'h0010;
         4'h5: line = 16'h0020;
         4'h6: line = 16'h0040;
         4'h7: line = 16'h0080;
         4'h8: line = 16'h0100;
         4'h9: line = 16'h0200;
         4'hA: line = 16'h0400;
         4'hB: line = 16'h0800;
         4'hC: line = 16'h1000;
         4'hD: line = 16'h2000;
         4'hE: line = 16'h4000;
         4'hF: line = 16'h8000;
         default: line = 16'h0000;
      endcase
      isa_line = line;
   endfunction

   // Steering of a pending event onto PCI, SMI or one ISA line, packed {isa, smi, pci}
   function automatic logic [17:0] steer(
      input logic pending,
      input logic [3:0] sel,
      input logic pci_route,
      input logic diag_route
   );
      logic to_pci;
      logic [17:0] lines;
      // Select 0 with the diagnostic bit overrides the route bit
      to_pci = pci_route | ((sel == csc_pkg::CSC_SEL_NONE) & diag_route);
      lines = {csc_pkg::CSC_IRQ_RST, 1'b0, 1'b0};
      // Routes are exclusive so the host never services one event twice
      if (pending) begin
         if (to_pci) begin
            lines[0] = 1'b1;
         end else if (sel == csc_pkg::CSC_SEL_SMI) begin
            lines[1] = 1'b1;
         end else begin
            lines[17:2] = isa_line(sel);
         end
      end
      steer = lines;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   csc_pkg::csc_state_s state_reg;
   csc_pkg::csc_state_s state_next;

   logic card_io;
   logic ring_on;
   logic [3:0] event_seen;
   logic [3:0] event_armed;
   logic [3:0] clear_bits;
   logic [7:0] view_now;
   logic hit_igc;
   logic hit_flags;
   logic hit_mask;
   logic hit_gctl;
   logic pending;
   logic [3:0] sel;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_next = state_reg;

      // Card pins are asynchronous: two flops, then a third for edge detection
      state_next.card_meta = card_pins(i_card_detect_n, i_card_ready, i_card_status_n,
         i_card_warn_n);
      state_next.card_sync = state_reg.card_meta;
      state_next.card_prev = state_reg.card_sync;

      card_io = state_reg.igc[csc_pkg::CSC_IGC_CARD_IO];
      ring_on = state_reg.igc[csc_pkg::CSC_IGC_RING];

      // Event detection
      event_seen = edge_events(state_reg.card_sync, state_reg.card_prev, card_io, ring_on);

      // Per-source enables from the low nibble of the route/mask register
      event_armed = event_seen & state_reg.route_mask[3:0];

      view_now = flag_view(state_reg.flags, state_reg.route_mask, state_reg.igc,
         state_reg.card_sync.status_n);

      // Register decode
      hit_igc = reg_hit(i_req, csc_pkg::CSC_IDX_IGC);
      hit_flags = reg_hit(i_req, csc_pkg::CSC_IDX_FLAGS);
      hit_mask = reg_hit(i_req, csc_pkg::CSC_IDX_MASK);
      hit_gctl = reg_hit(i_req, csc_pkg::CSC_IDX_GCTL);

      // Reads: one cycle latency, unmapped addresses return zero
      state_next.rdata = csc_pkg::CSC_REG_RST;
      if (i_req.rd) begin
         state_next.rdata = read_mux({hit_gctl, hit_igc, hit_mask, hit_flags}, view_now,
            state_reg.route_mask, state_reg.igc, state_reg.gctl);
      end

      // Flag clearing: only bits actually returned are cleared by a read
      clear_bits = clear_pick(state_reg.gctl[csc_pkg::CSC_GCTL_CLEAR_MODE], i_req.rd & hit_flags,
         i_req.wr & hit_flags, i_req.wdata[3:0], view_now[3:0]);

      // Set wins over a clear in the same cycle; disabled sources hold no flag
      state_next.flags = next_flags(state_reg.flags, clear_bits, event_armed,
         state_reg.route_mask[3:0]);

      // Register writes
      if (i_req.wr) begin
         if (hit_mask) begin
            state_next.route_mask = i_req.wdata;
         end
         if (hit_igc) begin
            state_next.igc = i_req.wdata;
         end
         if (hit_gctl) begin
            // Only the clear-mode bit lives here; the rest reads zero
            state_next.gctl = gctl_keep(i_req.wdata);
         end
      end

      // Interrupt steering, registered so outputs come from flops
      pending = any_pending(view_now);
      sel = state_reg.route_mask[7:4];
      {state_next.isa_irq, state_next.smi, state_next.pci_int} = steer(pending, sel,
         state_reg.igc[csc_pkg::CSC_IGC_PCI_ROUTE], i_diag_event_pci_route);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg.card_meta <= csc_pkg::CSC_CARD_RST;
         state_reg.card_sync <= csc_pkg::CSC_CARD_RST;
         state_reg.card_prev <= csc_pkg::CSC_CARD_RST;
         state_reg.flags <= csc_pkg::CSC_FLAGS_RST;
         state_reg.route_mask <= csc_pkg::CSC_REG_RST;
         state_reg.igc <= csc_pkg::CSC_REG_RST;
         state_reg.gctl <= csc_pkg::CSC_REG_RST;
         state_reg.rdata <= csc_pkg::CSC_REG_RST;
         state_reg.isa_irq <= csc_pkg::CSC_IRQ_RST;
         state_reg.smi <= 1'b0;
         state_reg.pci_int <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_reg_rdata = state_reg.rdata;
   assign o_isa_irq = state_reg.isa_irq;
   assign o_smi = state_reg.smi;
   assign o_pci_int = state_reg.pci_int;

endmodule

//--- verif/csc_irq_properties.sv
// Port-level assertions for the socket status-change block
`timescale 1ns/1ps
module csc_irq_properties (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire csc_pkg::csc_req_s i_req,
   input wire logic i_diag_event_pci_route,
   input wire logic [1:0] i_card_detect_n,
   input wire logic i_card_ready,
   input wire logic i_card_status_n,
   input wire logic i_card_warn_n,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [15:0] o_isa_irq,
   input wire logic o_smi,
   input wire logic o_pci_int
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   ////////////////////////////////////////
   // Cycles since a pin, a write or the diagnostic route moved; saturates
   logic [3:0] quiet_reg;
   logic [6:0] seen_reg;
   wire [6:0] seen_now = {i_card_detect_n, i_card_ready, i_card_status_n, i_card_warn_n, i_req.wr, i_diag_event_pci_route};
   wire [17:0] out_now = {o_isa_irq, o_smi, o_pci_int};
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         quiet_reg <= 4'hF;
         seen_reg <= 7'h00;
      end else begin
         seen_reg <= seen_now;
         quiet_reg <= (seen_now != seen_reg || i_req.wr) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
      end
   end
   ////////////////////////////////////////
   chk_rdata_idle: assert property (!i_req.rd |=> o_reg_rdata == 8'h00)
      else $error("read data seen without a read");
   chk_upper_zero: assert property (i_req.rd && !i_req.compat && i_req.addr == 12'h804 |=> o_reg_rdata[7:4] == 4'h0)
      else $error("status upper bits not zero");
   chk_compat_flags: assert property (i_req.rd && i_req.compat && i_req.addr[7:0] == 8'h04 |=> o_reg_rdata[7:4] == 4'h0)
      else $error("indexed status upper bits not zero");
   chk_unmapped_zero: assert property (i_req.rd && !i_req.compat && i_req.addr == 12'h810 |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_isa_spare: assert property (o_isa_irq[0] == 1'b0 && o_isa_irq[2] == 1'b0)
      else $error("unused interrupt line driven");
   chk_route_single: assert property ($onehot0(out_now))
      else $error("more than one interrupt route active");
   chk_mask_readback: assert property (i_req.wr && !i_req.compat && i_req.addr == 12'h805 ##1 !i_req.wr
      ##1 (i_req.rd && !i_req.wr && !i_req.compat && i_req.addr == 12'h805) |=> o_reg_rdata == $past(i_req.wdata, 3))
      else $error("enable register readback wrong");
   chk_irq_cause: assert property (|(out_now & ~$past(out_now)) |-> quiet_reg < 4'h8)
      else $error("interrupt raised without a cause");
   cover property (o_pci_int);
   cover property (o_smi);
   cover property (o_isa_irq[15]);
endmodule

bind csc_irq csc_irq_properties i_csc_irq_properties (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req(i_req),
   .i_diag_event_pci_route(i_diag_event_pci_route), .i_card_detect_n(i_card_detect_n), .i_card_ready(i_card_ready),
   .i_card_status_n(i_card_status_n), .i_card_warn_n(i_card_warn_n), .o_reg_rdata(o_reg_rdata),
   .o_isa_irq(o_isa_irq), .o_smi(o_smi), .o_pci_int(o_pci_int));

//--- verif/csc_card_model.sv
// Behavioural card in the socket driving the card-side pins
`timescale 1ns/1ps
module csc_card_model (
   input wire logic i_core_clk,
   input wire csc_pkg::csc_card_s i_want,
   input wire logic i_slow,
   output csc_pkg::csc_card_s o_pins
);
   csc_pkg::csc_card_s late_reg = csc_pkg::CSC_CARD_RST;
   initial o_pins = csc_pkg::CSC_CARD_RST;
   // Pins move between edges as a real card would; a slow card lags one cycle
   always @(posedge i_core_clk) begin
      late_reg <= i_want;
      o_pins <= #2 (i_slow ? late_reg : i_want);
   end
endmodule

//--- verif/csc_irq_bench.sv
// Self-checking bench for the socket status-change block
`timescale 1ns/1ps
module csc_irq_bench;
   logic i_core_clk, i_resetn, i_diag_event_pci_route, slow;
   csc_pkg::csc_req_s i_req;
   csc_pkg::csc_card_s want, pins, cur;
   logic [7:0] o_reg_rdata;
   logic [15:0] o_isa_irq;
   logic o_smi, o_pci_int;
   int error_cnt, comparisons, m_mask, m_igc, m_gctl, m_flags, d;
   csc_irq i_csc_irq (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req(i_req),
      .i_diag_event_pci_route(i_diag_event_pci_route), .i_card_detect_n(pins.detect_n), .i_card_ready(pins.ready),
      .i_card_status_n(pins.status_n), .i_card_warn_n(pins.warn_n), .o_reg_rdata(o_reg_rdata),
      .o_isa_irq(o_isa_irq), .o_smi(o_smi), .o_pci_int(o_pci_int));
   csc_card_model i_csc_card_model (.i_core_clk(i_core_clk), .i_want(want), .i_slow(slow), .o_pins(pins));
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Visible flags: I/O cards hide ready and warning, ring mode shows the live line
   function automatic int view();
      int v;
      v = m_flags & m_mask & 15;
      if (m_igc[5]) v &= 9;
      if (m_igc[7]) v = (v & 14) | (!cur.status_n & m_mask[0]);
      return v;
   endfunction
   // Packed as {isa lines, smi, pci}
   function automatic int route();
      int s;
      s = m_mask >> 4;
      if (view() == 0) return 0;
      if (m_igc[4] || (s == 0 && i_diag_event_pci_route)) return 1;
      if (s == 2) return 2;
      return s == 0 ? 0 : 1 << (s + 2);
   endfunction
   // Addresses below 100h are compatibility indices
   task automatic access(input bit wr, input logic [11:0] a, input logic [7:0] wd);
      logic [11:0] k;
      k = a < 12'h100 ? a + 12'h800 : a;
      @(posedge i_core_clk) #1;
      i_req = '{!wr, wr, a < 12'h100, a, wd};
      @(posedge i_core_clk) #1;
      i_req.rd = 1'b0;
      i_req.wr = 1'b0;
      if (wr) begin
         if (k == 12'h805) m_flags &= wd;
         if (k == 12'h805) m_mask = wd;
         if (k == 12'h803) m_igc = wd;
         if (k == 12'h81E) m_gctl = wd & 4;
         if (k == 12'h804 && m_gctl[2]) m_flags &= ~wd;
      end else begin
         d = k == 12'h803 ? m_igc : k == 12'h804 ? view() : k == 12'h805 ? m_mask : k == 12'h81E ? m_gctl : 0;
         check(o_reg_rdata, d);
         if (k == 12'h804 && !m_gctl[2]) m_flags &= ~view();
      end
   endtask
   task automatic card(input csc_pkg::csc_card_s nv);
      want = nv;
      repeat (8) @(posedge i_core_clk);
      #1;
      if (cur.detect_n != nv.detect_n && m_mask[3]) m_flags |= 8;
      if (!cur.ready && nv.ready && m_mask[2] && !m_igc[5]) m_flags |= 4;
      if (cur.warn_n && !nv.warn_n && m_mask[1] && !m_igc[5]) m_flags |= 2;
      if (cur.status_n && !nv.status_n && m_mask[0] && !m_igc[7]) m_flags |= 1;
      cur = nv;
      check({o_isa_irq, o_smi, o_pci_int}, route());
   endtask
   ////////////////////////////////////////
   initial begin
      logic [11:0] tbl [6] = '{12'h803, 12'h804, 12'h805, 12'h81E, 12'h810, 12'h004};
      d = $urandom(71);
      {error_cnt, comparisons, m_mask, m_igc, m_gctl, m_flags} = '0;
      i_resetn = 1'b0;
      i_req = '0;
      i_diag_event_pci_route = 1'b0;
      slow = 1'b0;
      want = csc_pkg::CSC_CARD_RST;
      cur = want;
      repeat (8) @(posedge i_core_clk);
      #1 i_resetn = 1'b1;
      foreach (tbl[i]) access(0, tbl[i], 8'h00);
      card(5'h1E);
      access(0, 12'h804, 8'h00);
      for (int p = 0; p < 6; p++) begin
         access(1, 12'h805, 8'h00);
         access(1, 12'h803, p % 3 == 0 ? 8'h00 : p % 3 == 1 ? 8'h20 : 8'h80);
         access(1, 12'h81E, p < 3 ? 8'h00 : 8'h04);
         access(1, 12'h805, 8'(p * 32 + 63));
         access(0, 12'h805, 8'h00);
         repeat (12) begin
            d = $urandom;
            slow = d[8];
            card(d[4:0]);
            access(0, 12'h804, 8'h00);
            access(1, 12'h804, 8'(d >> 12));
         end
      end
      access(1, 12'h803, 8'h00);
      access(1, 12'h805, 8'h08);
      card(cur ^ 5'h08);
      for (int r = 0; r < 64; r++) begin
         i_diag_event_pci_route = r[4];
         access(1, 12'h803, {2'h0, r[5], 5'h00});
         access(1, 12'h805, {r[3:0], 4'h8});
         repeat (2) @(posedge i_core_clk);
         #1 check({o_isa_irq, o_smi, o_pci_int}, route());
      end
      complete_run();
   end
   initial begin
      #50000;
      error_cnt++;
      complete_run();
   end
endmodule
